/* rtl/ddsp_pkg.sv */
package ddsp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DDSP_DATA_W = 36;
  localparam int DDSP_LANE_W = 9;
  localparam int DDSP_ADDR_W = 20;
  localparam int DDSP_BURST_LEN = 2;
  localparam int DDSP_FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Pin sampling and timing; latencies counted in link half cycles, strap wait in clock cycles
  // ----------------------------------------------------------------
  localparam int DDSP_SYNC_STAGES = 3;
  localparam int DDSP_LAT_HALF_PLL = 5;
  localparam int DDSP_LAT_HALF_BYP = 2;
  localparam int DDSP_SCHED_D = DDSP_LAT_HALF_PLL + 1;
  localparam logic [1:0] DDSP_STRAP_WAIT = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic DDSP_TERM_RST = 1'b1;
  localparam logic DDSP_ODT_RST = 1'b0;

  typedef enum logic [1:0] {
    DDSP_WR_IDLE,
    DDSP_WR_W0,
    DDSP_WR_W1
  } ddsp_wr_state_t;

endpackage : ddsp_pkg

/* rtl/ddsp_store.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Write-data FIFO
// ------------------------------------------------------------------
module ddsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  wire do_push = ce_i && in_valid_i && in_ready_o;
  wire do_pop = ce_i && out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];

  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem_r[wp_r] <= in_data_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_push)
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (do_pop)
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule : ddsp_fifo

// ------------------------------------------------------------------
// Memory core: two equal arrays, one per burst word
// ------------------------------------------------------------------
module ddsp_mem #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 36,
  parameter int LANE_W = 9
) (
  input wire logic clk_i,
  input wire logic ce_i,
  // Write port, lane masked
  input wire logic we_i,
  input wire logic wbank_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [DATA_W/LANE_W-1:0] lane_en_i,
  input wire logic [DATA_W-1:0] wdata_i,
  // Read port, both arrays at once
  input wire logic re_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [2*DATA_W-1:0] rdata_o
);
  localparam int NL = DATA_W / LANE_W;
  genvar b;
  genvar l;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      logic [DATA_W-1:0] arr_r [2**ADDR_W];
      for (l = 0; l < NL; l++)
      begin : g_lane
        always_ff @(posedge clk_i)
        begin
          if (ce_i && we_i && (wbank_i == b[0]) && lane_en_i[l])
            arr_r[waddr_i][l*LANE_W +: LANE_W] <=
              wdata_i[l*LANE_W +: LANE_W];
        end
      end
      always_ff @(posedge clk_i)
      begin
        if (ce_i && re_i)
          rdata_o[b*DATA_W +: DATA_W] <= arr_r[raddr_i];
      end
    end
  endgenerate
endmodule : ddsp_mem

/* rtl/ddsp_port.sv */
`timescale 1ns/1ps
// Overview of operation
// - Write data pins sampled at true and complement clock rises.
// - Read data driven out at true and complement clock rises.
// - Data pins released whenever no read word is being driven.
// - Low load strobe, seen at true clock rise, starts a bus cycle.
// - Each loaded address moves exactly two words, read or write.
// - Byte selects sampled on the same edge as their data word.
// - Each byte select gates one nine-bit lane, select n bits 9n+8:9n.
// - Unselected bytes are ignored; stored byte stays unchanged.
// - One shared address bus sampled at the true clock rise.
// - Core is two equal arrays, each half the words, full width.
// - Direction high on load means read, low means write.
// - Read-valid flag marks read data, changing with the echo strobes.
// - Termination range latched at power-up: low 3.33, high 1.66 range.
// - A floating termination pin gives the high range; the code has no pull, so the range is high only before the latch.
// - Accesses start and controls are captured at the true clock rise.
// - Termination enabled only during writes, off during reads.
// - Bypass pin low: no PLL, one-cycle read latency mode.
module ddsp_port import ddsp_pkg::*; #(
  parameter int DATA_W = DDSP_DATA_W,
  parameter int ADDR_W = DDSP_ADDR_W,
  parameter int FIFO_DEPTH = DDSP_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Link clocks and controls
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic cycle_load_n_i,
  input wire logic rw_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W/DDSP_LANE_W-1:0] byte_write_sel_n_i,
  // Data pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // Read status and echo
  output logic read_valid_flag_o,
  output logic echo_strobe_o,
  output logic echo_strobe_n_o,
  // Straps and termination
  input wire logic termination_range_sel_i,
  input wire logic pll_bypass_n_i,
  output logic odt_en_o,
  output logic term_range_high_o,
  output logic write_stall_o
);
  localparam int NL = DATA_W / DDSP_LANE_W;
  localparam int P_BWS = DATA_W;
  localparam int P_ADDR = P_BWS + NL;
  localparam int P_BYP = P_ADDR + ADDR_W;
  localparam int P_TERM = P_BYP + 1;
  localparam int P_RW = P_TERM + 1;
  localparam int P_LD = P_RW + 1;
  localparam int P_KN = P_LD + 1;
  localparam int P_K = P_KN + 1;
  localparam int PIN_W = P_K + 1;
  localparam int FW = ADDR_W + 1 + NL + DATA_W;
  localparam int SD = DDSP_SCHED_D;

  // ----------------------------------------------------------------
  // Pin sampling: three stages, a change counts once two agree
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;
  logic [PIN_W-1:0] filt_r;
  wire [PIN_W-1:0] pin_raw = {k_i, k_n_i, cycle_load_n_i, rw_i,
    termination_range_sel_i, pll_bypass_n_i, addr_i,
    byte_write_sel_n_i, dq_i};
  wire [PIN_W-1:0] pin_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end
    else if (ce_i)
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= pin_nxt;
    end
  end

  wire k_rise = ce_i && pin_nxt[P_K] && !filt_r[P_K];
  wire kn_rise = ce_i && pin_nxt[P_KN] && !filt_r[P_KN];
  wire half_edge = k_rise || kn_rise;
  wire ld_n_s = pin_nxt[P_LD];
  wire rw_s = pin_nxt[P_RW];
  wire bypass_s = !pin_nxt[P_BYP];
  wire [ADDR_W-1:0] addr_s = pin_nxt[P_ADDR +: ADDR_W];
  wire [NL-1:0] bws_n_s = pin_nxt[P_BWS +: NL];
  wire [DATA_W-1:0] dq_s = pin_nxt[DATA_W-1:0];

  // ----------------------------------------------------------------
  // Load decode
  // ----------------------------------------------------------------
  // strobe taken only at a true clock rise
  wire ld_any = k_rise && !ld_n_s;
  // direction and shared address with the load
  wire ld_rd = ld_any && rw_s;
  wire ld_wr = ld_any && !rw_s;

  // ----------------------------------------------------------------
  // Write capture: word 0 at next true rise, word 1 at complement rise
  // ----------------------------------------------------------------
  ddsp_wr_state_t wr_state_r;
  ddsp_wr_state_t wr_state_nxt;
  logic [ADDR_W-1:0] wr_addr_r;
  wire wr_w0 = k_rise && (wr_state_r == DDSP_WR_W0);
  wire wr_w1 = kn_rise && (wr_state_r == DDSP_WR_W1);
  wire push = wr_w0 || wr_w1;
  // data and byte selects from the same edge, two words
  wire [FW-1:0] push_data = {wr_addr_r, wr_w1, bws_n_s, dq_s};

  always_comb
  begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      DDSP_WR_IDLE: if (ld_wr) wr_state_nxt = DDSP_WR_W0;
      DDSP_WR_W0: if (k_rise) wr_state_nxt = DDSP_WR_W1;
      DDSP_WR_W1: if (kn_rise) wr_state_nxt = DDSP_WR_IDLE;
      default: wr_state_nxt = DDSP_WR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_state_r <= DDSP_WR_IDLE;
      wr_addr_r <= '0;
    end
    else if (ce_i)
    begin
      wr_state_r <= wr_state_nxt;
      if (ld_wr)
        wr_addr_r <= addr_s;
    end
  end

  // ----------------------------------------------------------------
  // Write FIFO and memory core
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic [2*DATA_W-1:0] mem_rdata;
  // Reads own the core port; queued writes wait behind them
  wire drain_ready = !ld_rd;
  wire mem_we = fifo_out_valid && drain_ready;
  wire [ADDR_W-1:0] f_addr = fifo_out_data[FW-1 -: ADDR_W];
  wire f_bank = fifo_out_data[NL+DATA_W];
  wire [NL-1:0] f_bws_n = fifo_out_data[DATA_W +: NL];

  ddsp_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain_ready),
    .out_data_o(fifo_out_data)
  );

  // word 0 to one array, word 1 to the other
  // active-low selects become per-lane write enables
  ddsp_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANE_W(DDSP_LANE_W)
  ) u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .wbank_i(f_bank),
    .waddr_i(f_addr),
    .lane_en_i(~f_bws_n),
    .wdata_i(fifo_out_data[DATA_W-1:0]),
    .re_i(ld_rd),
    .raddr_i(addr_s),
    .rdata_o(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Read scheduling in link half cycles
  // ----------------------------------------------------------------
  logic rd_slot_r;
  logic cap_r;
  logic cap_slot_r;
  logic [2*DATA_W-1:0] hold_r [2];
  logic [SD-1:0] sch_v_r;
  logic [SD-1:0] sch_w_r;
  logic [SD-1:0] sch_s_r;
  logic [SD-1:0] sch_v_nxt;
  logic [SD-1:0] sch_w_nxt;
  logic [SD-1:0] sch_s_nxt;
  // latency by bypass pin, 2 or 5 half cycles
  wire [2:0] w0_pos = bypass_s ? 3'(DDSP_LAT_HALF_BYP - 1) :
    3'(DDSP_LAT_HALF_PLL - 1);
  wire [2:0] w1_pos = w0_pos + 3'h1;
  wire [2*DATA_W-1:0] out_pair = hold_r[sch_s_r[0]];
  wire [DATA_W-1:0] out_word = sch_w_r[0] ?
    out_pair[2*DATA_W-1 -: DATA_W] : out_pair[DATA_W-1:0];

  always_comb
  begin
    sch_v_nxt = sch_v_r >> 1;
    sch_w_nxt = sch_w_r >> 1;
    sch_s_nxt = sch_s_r >> 1;
    // each read schedules exactly two words
    if (ld_rd)
    begin
      sch_v_nxt[w0_pos] = 1'b1;
      sch_w_nxt[w0_pos] = 1'b0;
      sch_s_nxt[w0_pos] = rd_slot_r;
      sch_v_nxt[w1_pos] = 1'b1;
      sch_w_nxt[w1_pos] = 1'b1;
      sch_s_nxt[w1_pos] = rd_slot_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_slot_r <= 1'b0;
      cap_r <= 1'b0;
      cap_slot_r <= 1'b0;
      hold_r[0] <= '0;
      hold_r[1] <= '0;
      sch_v_r <= '0;
      sch_w_r <= '0;
      sch_s_r <= '0;
    end
    else if (ce_i)
    begin
      cap_r <= ld_rd;
      if (ld_rd)
      begin
        rd_slot_r <= !rd_slot_r;
        cap_slot_r <= rd_slot_r;
      end
      if (cap_r)
        hold_r[cap_slot_r] <= mem_rdata;
      if (half_edge)
      begin
        sch_v_r <= sch_v_nxt;
        sch_w_r <= sch_w_nxt;
        sch_s_r <= sch_s_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins, echo strobes, termination
  // ----------------------------------------------------------------
  // One count more than the wait, so the strap has passed the filter
  logic [2:0] init_cnt_r;
  wire strap_done = (init_cnt_r == 3'(DDSP_STRAP_WAIT) + 3'h1);
  // termination on for a write, off while any read is pending
  wire odt_nxt = (wr_state_nxt != DDSP_WR_IDLE) && (sch_v_nxt == '0)
    && !ld_rd;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      read_valid_flag_o <= 1'b0;
      echo_strobe_o <= 1'b0;
      echo_strobe_n_o <= 1'b0;
      odt_en_o <= DDSP_ODT_RST;
      term_range_high_o <= DDSP_TERM_RST;
      write_stall_o <= 1'b0;
      init_cnt_r <= '0;
    end
    else if (ce_i)
    begin
      echo_strobe_o <= pin_nxt[P_K];
      echo_strobe_n_o <= pin_nxt[P_KN];
      odt_en_o <= odt_nxt;
      write_stall_o <= !fifo_in_ready;
      // range caught once after power-up, high by default
      if (!strap_done)
      begin
        init_cnt_r <= init_cnt_r + 3'h1;
        if (init_cnt_r == 3'(DDSP_STRAP_WAIT))
          term_range_high_o <= pin_nxt[P_TERM];
      end
      // drive or release at every link half edge
      if (half_edge)
      begin
        dq_oe_o <= sch_v_r[0];
        read_valid_flag_o <= sch_v_r[0];
        dq_o <= sch_v_r[0] ? out_word : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [2:0] since_rd_r;
  logic rd_byp_r;
  logic [1:0] run_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      since_rd_r <= 3'h7;
      rd_byp_r <= 1'b0;
      run_r <= '0;
    end
    else if (half_edge)
    begin
      run_r <= dq_oe_o ? run_r + 2'h1 : 2'h0;
      if (ld_rd)
      begin
        since_rd_r <= '0;
        rd_byp_r <= bypass_s;
      end
      else if (since_rd_r != 3'h7)
        since_rd_r <= since_rd_r + 3'h1;
    end
  end

  chk_hiz_no_read: assert property (
    !read_valid_flag_o |-> !dq_oe_o)
    else $error("data pins driven without valid read data");
  chk_valid_on_edge: assert property (
    $changed(read_valid_flag_o) |-> $past(half_edge))
    else $error("read valid changed off a link edge");
  chk_read_latency: assert property (
    (half_edge && since_rd_r == 3'h4 && !rd_byp_r) |=> dq_oe_o)
    else $error("first read word not out after 2.5 cycles");
  chk_bypass_latency: assert property (
    (half_edge && since_rd_r == 3'h1 && rd_byp_r) |=> dq_oe_o)
    else $error("bypass read word not out after one cycle");
  chk_burst_two: assert property (
    $fell(dq_oe_o) |-> run_r == 2'h2)
    else $error("read burst not exactly two words");
  chk_odt_read_off: assert property (
    dq_oe_o |-> !odt_en_o)
    else $error("termination on while driving read data");
  chk_load_true_edge: assert property (
    (wr_state_r == DDSP_WR_IDLE && !ld_wr) |=>
      wr_state_r == DDSP_WR_IDLE)
    else $error("write started without a load at true rise");
  chk_write_words: assert property (
    wr_w0 |-> ##[1:16] (wr_w1 && push))
    else $error("second write word not captured");
  chk_term_default: assert property (
    !strap_done |-> term_range_high_o)
    else $error("termination range not high before latch");
  chk_term_stable: assert property (
    strap_done |=> $stable(term_range_high_o))
    else $error("termination range changed after power-up");

  cov_read_burst: cover property ($fell(dq_oe_o) && !rd_byp_r);
  cov_bypass_read: cover property ($rose(dq_oe_o) && rd_byp_r);
  cov_write_burst: cover property (wr_w1 && fifo_in_ready);
  cov_write_stall: cover property (write_stall_o);
endmodule : ddsp_port

/* verif/ddsp_host.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Memory controller driving the link pins
// ------------------------------------------------------------------
module ddsp_host #(
  parameter int AW = 6
) (
  // Clock
  input wire logic clk_i,
  // Link clocks and controls
  output logic k_o,
  output logic k_n_o,
  output logic cycle_load_n_o,
  output logic rw_o,
  output logic [AW-1:0] addr_o,
  output logic [3:0] byte_write_sel_n_o,
  // Write data
  output logic [35:0] dq_o
);
  initial
  begin
    k_o = 1'b0;
    k_n_o = 1'b1;
    cycle_load_n_o = 1'b1;
    rw_o = 1'b1;
    addr_o = '0;
    byte_write_sel_n_o = 4'hf;
    dq_o = 36'h0_0000_0000;
  end

  // Half cycle of 4 clocks, then the next link edge
  task automatic step(input logic kv, input logic ld);
    repeat (4) @(posedge clk_i);
    #2;
    k_o = kv;
    k_n_o = ~kv;
    cycle_load_n_o = ld;
  endtask : step

  // address pins wired in reverse order
  function automatic logic [AW-1:0] perm(input logic [AW-1:0] a);
    return {<<{a}};
  endfunction : perm

  // one load per two k rises
  task automatic wr(input logic [AW-1:0] a, input logic [35:0] w0,
    input logic [35:0] w1, input logic [3:0] b0, input logic [3:0] b1);
    rw_o = 1'b0;
    addr_o = perm(a);
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    // word and selects at each rising edge
    dq_o = w0;
    byte_write_sel_n_o = b0;
    step(1'b0, 1'b1);
    dq_o = w1;
    byte_write_sel_n_o = b1;
    repeat (4) @(posedge clk_i);
    #2;
    // Released lines show the inverse of the last value
    dq_o = ~w1;
    byte_write_sel_n_o = 4'hf;
  endtask : wr

  // Load at k rise, or only at k_n rise when at_kn is set
  task automatic rd(input logic [AW-1:0] a, input logic at_kn);
    rw_o = 1'b1;
    addr_o = perm(a);
    step(1'b1, at_kn);
    step(1'b0, ~at_kn);
    for (int i = 2; i < 8; i++)
    begin
      step(~i[0], 1'b1);
    end
    repeat (4) @(posedge clk_i);
  endtask : rd
endmodule : ddsp_host

/* verif/ddsp_port_bench.sv */
`timescale 1ns/1ps

module ddsp_port_bench;
  import ddsp_pkg::*;
  localparam int AW = 6;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic term_sel = 1'b1;
  logic bypass_n = 1'b1;
  logic k, k_n, ld_n, rw, dev_oe, valid, echo, echo_n, termination_range_sel, range_hi, stall;
  logic [AW-1:0] addr;
  logic [3:0] bws_n;
  logic [35:0] host_dq, dev_dq, dq_pin;
  logic [35:0] sh0 [0:63];
  logic [35:0] sh1 [0:63];
  int n_mismatch = 0;
  int compares = 0;
  int odt_cnt = 0;
  int oe_cnt = 0;

  always #50 clk_i = ~clk_i;
  assign dq_pin = dev_oe ? dev_dq : host_dq;

  always @(posedge clk_i)
  begin
    if (termination_range_sel === 1'b1) odt_cnt++;
    if (dev_oe === 1'b1) oe_cnt++;
  end

  ddsp_port #(.ADDR_W(AW)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .k_i(k), .k_n_i(k_n),
    .cycle_load_n_i(ld_n), .rw_i(rw), .addr_i(addr),
    .byte_write_sel_n_i(bws_n), .dq_i(dq_pin), .dq_o(dev_dq),
    .dq_oe_o(dev_oe), .read_valid_flag_o(valid), .echo_strobe_o(echo),
    .echo_strobe_n_o(echo_n), .termination_range_sel_i(term_sel),
    .pll_bypass_n_i(bypass_n), .odt_en_o(termination_range_sel),
    .term_range_high_o(range_hi), .write_stall_o(stall)
  );

  ddsp_host #(.AW(AW)) host (
    .clk_i(clk_i), .k_o(k), .k_n_o(k_n), .cycle_load_n_o(ld_n),
    .rw_o(rw), .addr_o(addr), .byte_write_sel_n_o(bws_n), .dq_o(host_dq)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [37:0] seen,
    input logic [37:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // lane n is bits 9n+8:9n, kept while its select is high
  function automatic logic [35:0] merge(input logic [35:0] old,
    input logic [35:0] nw, input logic [3:0] b);
    logic [35:0] r;
    r = old;
    for (int n = 0; n < 4; n++)
    begin
      if (!b[n]) r[9*n +: 9] = nw[9*n +: 9];
    end
    return r;
  endfunction : merge

  task automatic wr(input logic [AW-1:0] a, input logic [35:0] w0,
    input logic [35:0] w1, input logic [3:0] b0, input logic [3:0] b1);
    odt_cnt = 0;
    oe_cnt = 0;
    host.wr(a, w0, w1, b0, b1);
    sh0[a] = merge(sh0[a], w0, b0);
    sh1[a] = merge(sh1[a], w1, b1);
    repeat (16) @(posedge clk_i);
    #3;
    check("odt in write", 38'(odt_cnt > 0), 38'h1);
    check("drive in write", 38'(oe_cnt), 38'h0);
    check("stall in write", 38'(stall), 38'h0);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input int h);
    int i;
    i = 0;
    odt_cnt = 0;
    fork
      host.rd(a, 1'b0);
      begin
        while (i < 80 && valid !== 1'b1)
        begin
          @(posedge clk_i);
          #3;
          i++;
        end
        check("latency", 38'(i >= 4*h+6 && i <= 4*h+10), 38'h1);
        @(posedge clk_i);
        #3;
        check("word0", {dev_oe, valid, dq_pin}, {2'b11, sh0[a]});
        repeat (4) @(posedge clk_i);
        #3;
        check("word1", {dev_oe, valid, dq_pin}, {2'b11, sh1[a]});
        repeat (4) @(posedge clk_i);
        #3;
        check("release", {dev_oe, valid, dev_dq}, 38'h0);
      end
    join
    check("odt in read", 38'(odt_cnt), 38'h0);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_strap(input logic s);
    rst_b_i = 1'b0;
    term_sel = s;
    repeat (4) @(posedge clk_i);
    #2;
    check("range in reset", 38'(range_hi), 38'h1);
    check("idle in reset", {dev_oe, valid, termination_range_sel}, 38'h0);
    rst_b_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #2;
    check("range strap", 38'(range_hi), 38'(s));
    check("echo idle", {echo, echo_n}, {k, k_n});
  endtask : t_strap

  task automatic t_burst();
    wr(5, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    wr(6, 36'h5_5555_5555, 36'ha_aaaa_aaaa, 4'h0, 4'h0);
    rd(5, 5);
    rd(6, 5);
  endtask : t_burst

  task automatic t_lanes();
    for (int n = 0; n < 4; n++)
    begin
      wr(5, 36'h0_f0f0_f0f0, 36'h0_0f0f_0f0f, ~(4'h1 << n), ~(4'h8 >> n));
      rd(5, 5);
    end
    wr(6, 36'h0_0000_0000, 36'h0_0000_0000, 4'hf, 4'hf);
    rd(6, 5);
  endtask : t_lanes

  task automatic t_bypass();
    @(posedge clk_i);
    #2;
    bypass_n = 1'b0;
    wr(9, 36'h3_c3c3_c3c3, 36'hc_3c3c_3c3c, 4'h0, 4'h0);
    rd(9, 2);
    bypass_n = 1'b1;
  endtask : t_bypass

  task automatic t_no_load();
    oe_cnt = 0;
    host.rd(5, 1'b1);
    repeat (8) @(posedge clk_i);
    check("load at k_n", 38'(oe_cnt), 38'h0);
  endtask : t_no_load

  initial
  begin
    t_strap(1'b0);
    t_strap(1'b1);
    t_burst();
    t_lanes();
    t_bypass();
    t_no_load();
    close_out();
  end

  initial
  begin
    #1_000_000;
    n_mismatch++;
    close_out();
  end
endmodule : ddsp_port_bench
